/* design/rlc_cmd_decode.v */
// splits one command word into single-cycle command strobes
`timescale 1ns/10ps
`default_nettype none
`include "rlc_regs.vh"

module rlc_cmd_decode (
	input wire wr,
	input wire [31:0] word,
	output wire go_local,
	output wire go_remote,
	output wire lock_set,
	output wire lock_clr,
	output wire start,
	output wire query,
	output wire abort,
	output wire trig,
	output wire out_on,
	output reg unit_wr,
	output reg [1:0] unit_code
);
	wire [2:0] name;

	// every strobe is qualified by the write so an idle port stays silent
	assign go_local = wr & word[`RLC_CMD_LOCAL];
	assign go_remote = wr & word[`RLC_CMD_REMOTE];
	assign lock_set = wr & word[`RLC_CMD_LOCK_SET];
	assign lock_clr = wr & word[`RLC_CMD_LOCK_CLR];
	assign start = wr & word[`RLC_CMD_START];
	assign query = wr & (word[`RLC_CMD_READQ] | word[`RLC_CMD_MEASQ]);
	assign abort = wr & word[`RLC_CMD_ABORT];
	assign trig = wr & word[`RLC_CMD_TRIG];
	assign out_on = wr & word[`RLC_CMD_OUT_ON];
	assign name = word[`RLC_CMD_UNIT_MSB:`RLC_CMD_UNIT_LSB];

	// unit names; an unknown name is dropped rather than guessed
	always @* begin
		unit_wr = 1'b0;
		unit_code = `RLC_UNIT_C;
		if (wr && word[`RLC_CMD_UNIT_WR]) begin
			case (name)
				`RLC_NAME_C, `RLC_NAME_CEL: begin
					unit_wr = 1'b1;
					unit_code = `RLC_UNIT_C;
				end
				`RLC_NAME_F, `RLC_NAME_FAR: begin
					unit_wr = 1'b1;
					unit_code = `RLC_UNIT_F;
				end
				`RLC_NAME_K: begin
					unit_wr = 1'b1;
					unit_code = `RLC_UNIT_K;
				end
				default: begin
					unit_wr = 1'b0;
				end
			endcase
		end
	end
endmodule // rlc_cmd_decode
`default_nettype wire

/* design/rlc_control.v */
// remote/local, key lockout, cycle control and unit selection over apb
//
// Function
// - remote, local and lockout commands act identically from gpib and serial.
// - front-panel keys work during serial traffic unless locked out in remote.
// - go-local leaves remote and re-enables front-panel keys.
// - enter-remote puts the instrument into the remote state.
// - in remote with lockout asserted, front-panel key presses are ignored.
// - lockout command sets or clears flag; cleared flag keeps keys usable.
// - output-off key still turns the output off under lockout.
// - trigger commands act only in calibration mode, else discarded.
// - cycle start leaves idle and begins control-measure operation.
// - read and measure queries also leave idle before returning results.
// - abort stops operation, returns to idle and switches output off.
// - unit command selects celsius, fahrenheit or kelvin; query reports it.
// - selected unit applies to commanded and returned temperatures.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "rlc_regs.vh"

module rlc_control (
	input wire clk_sys,
	input wire reset_n,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire key_valid,
	input wire [5:0] key_code,
	input wire key_output_off,
	input wire [31:0] reading_c,
	output reg remote,
	output reg lockout,
	output reg idle,
	output reg output_on,
	output reg key_pass,
	output reg [5:0] key_pass_code,
	output reg trigger_fire,
	output reg result_req,
	output reg [1:0] unit_sel,
	output reg [31:0] setpoint_c
);
	// ***********************************************************
	// cycle state machine encoding
	// ***********************************************************
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_QUERY = 2'h2;

	reg [1:0] state;
	reg [1:0] next_state;
	reg cal_mode;
	wire access;
	wire wr_done;
	wire rd_phase;
	wire mapped;
	wire wr_serial;
	wire wr_gpib;

	// ***********************************************************
	// apb decode
	// ***********************************************************

	// one wait state: pready rises a cycle into the access phase
	assign access = psel & penable;
	assign wr_done = access & pready & pwrite;
	assign rd_phase = access & ~pready & ~pwrite;
	assign mapped = (paddr == `RLC_OFF_CMD_SERIAL) |
		(paddr == `RLC_OFF_CMD_GPIB) |
		(paddr == `RLC_OFF_CTRL) |
		(paddr == `RLC_OFF_STATUS) |
		(paddr == `RLC_OFF_TEMP_SET) |
		(paddr == `RLC_OFF_TEMP_READ);
	assign wr_serial = wr_done & mapped & (paddr == `RLC_OFF_CMD_SERIAL);
	assign wr_gpib = wr_done & mapped & (paddr == `RLC_OFF_CMD_GPIB);

	// ***********************************************************
	// command decoders, one per host port
	// ***********************************************************
	wire s_local, s_remote, s_lset, s_lclr, s_start, s_query;
	wire s_abort, s_trig, s_on, s_uwr;
	wire [1:0] s_unit;
	wire g_local, g_remote, g_lset, g_lclr, g_start, g_query;
	wire g_abort, g_trig, g_on, g_uwr;
	wire [1:0] g_unit;

	// same decoder instance type for both ports keeps them identical
	rlc_cmd_decode u_dec_serial (
		.wr(wr_serial),
		.word(pwdata),
		.go_local(s_local),
		.go_remote(s_remote),
		.lock_set(s_lset),
		.lock_clr(s_lclr),
		.start(s_start),
		.query(s_query),
		.abort(s_abort),
		.trig(s_trig),
		.out_on(s_on),
		.unit_wr(s_uwr),
		.unit_code(s_unit)
	);

	rlc_cmd_decode u_dec_gpib (
		.wr(wr_gpib),
		.word(pwdata),
		.go_local(g_local),
		.go_remote(g_remote),
		.lock_set(g_lset),
		.lock_clr(g_lclr),
		.start(g_start),
		.query(g_query),
		.abort(g_abort),
		.trig(g_trig),
		.out_on(g_on),
		.unit_wr(g_uwr),
		.unit_code(g_unit)
	);

	// only one apb write per cycle, so or-ing the ports never collides
	wire c_local = s_local | g_local;
	wire c_remote = s_remote | g_remote;
	wire c_lset = s_lset | g_lset;
	wire c_lclr = s_lclr | g_lclr;
	wire c_start = s_start | g_start;
	wire c_query = s_query | g_query;
	wire c_abort = s_abort | g_abort;
	wire c_trig = s_trig | g_trig;
	wire c_on = s_on | g_on;
	wire c_uwr = s_uwr | g_uwr;
	wire [1:0] c_unit = s_uwr ? s_unit : g_unit;

	// ***********************************************************
	// unit conversion for setpoint writes and readings
	// ***********************************************************
	wire [31:0] set_cel;
	wire [31:0] set_user;
	wire [31:0] read_cel_unused;
	wire [31:0] read_user;

	rlc_temp_conv u_conv_set (
		.unit(unit_sel),
		.user_in(pwdata),
		.cel_in(setpoint_c),
		.cel_out(set_cel),
		.user_out(set_user)
	);

	rlc_temp_conv u_conv_read (
		.unit(unit_sel),
		.user_in(32'h00000000),
		.cel_in(reading_c),
		.cel_out(read_cel_unused),
		.user_out(read_user)
	);

	// ***********************************************************
	// key gating
	// ***********************************************************

	// keys are live unless remote and lockout are both set
	wire keys_en = ~(remote & lockout);

	// ***********************************************************
	// apb handshake and read data
	// ***********************************************************

	// read data is captured with pready so it is stable when sampled
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (ce) begin
			pready <= access & ~pready;
			pslverr <= access & ~pready & ~mapped;
			if (rd_phase) begin
				case (paddr)
					`RLC_OFF_CTRL: begin
						prdata <= {31'h00000000, cal_mode};
					end
					`RLC_OFF_STATUS: begin
						prdata <= {24'h000000, unit_sel, cal_mode,
							keys_en, output_on, idle, lockout,
							remote};
					end
					`RLC_OFF_TEMP_SET: begin
						prdata <= set_user;
					end
					`RLC_OFF_TEMP_READ: begin
						prdata <= read_user;
					end
					default: begin
						prdata <= 32'h00000000;
					end
				endcase
			end
		end
	end

	// ***********************************************************
	// remote and lockout flags
	// ***********************************************************

	// local wins over remote if both come in one word: safer for the user
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			remote <= 1'b0;
			lockout <= 1'b0;
		end else if (ce) begin
			if (c_local) begin
				remote <= 1'b0;
			end else if (c_remote) begin
				remote <= 1'b1;
			end
			if (c_lset) begin
				lockout <= 1'b1;
			end else if (c_lclr) begin
				lockout <= 1'b0;
			end
		end
	end

	// ***********************************************************
	// control register, unit and setpoint
	// ***********************************************************

	// setpoint is kept in celsius so a later unit change reads it anew
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cal_mode <= 1'b0;
			unit_sel <= `RLC_RST_UNIT;
			setpoint_c <= `RLC_RST_SETPOINT;
		end else if (ce) begin
			if (wr_done && paddr == `RLC_OFF_CTRL) begin
				cal_mode <= pwdata[`RLC_CTRL_CAL];
			end
			if (c_uwr) begin
				unit_sel <= c_unit;
			end
			if (wr_done && paddr == `RLC_OFF_TEMP_SET) begin
				setpoint_c <= set_cel;
			end
		end
	end

	// ***********************************************************
	// control-measure cycle
	// ***********************************************************

	// abort takes priority over any start arriving in the same cycle
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (c_abort) begin
					next_state = ST_IDLE;
				end else if (c_query) begin
					next_state = ST_QUERY;
				end else if (c_start) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (c_abort) begin
					next_state = ST_IDLE;
				end else if (c_query) begin
					next_state = ST_QUERY;
				end
			end
			ST_QUERY: begin
				if (c_abort) begin
					next_state = ST_IDLE;
				end else begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// the query strobe rises in the same cycle as the exit from idle
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			idle <= 1'b1;
			result_req <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			idle <= (next_state == ST_IDLE);
			result_req <= (next_state == ST_QUERY);
		end
	end

	// ***********************************************************
	// output enable
	// ***********************************************************

	// off requests beat an on request in the same cycle
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			output_on <= 1'b0;
		end else if (ce) begin
			if (c_abort) begin
				output_on <= 1'b0;
			end else if (key_valid && key_output_off) begin
				output_on <= 1'b0;
			end else if (c_on) begin
				output_on <= 1'b1;
			end
		end
	end

	// ***********************************************************
	// front-panel keys and trigger
	// ***********************************************************

	// a dropped key is gone for good; no queue holds it for later
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			key_pass <= 1'b0;
			key_pass_code <= 6'h00;
			trigger_fire <= 1'b0;
		end else if (ce) begin
			key_pass <= key_valid & ~key_output_off & keys_en;
			if (key_valid && keys_en) begin
				key_pass_code <= key_code;
			end
			trigger_fire <= c_trig & cal_mode;
		end
	end
endmodule // rlc_control
`default_nettype wire

/* design/rlc_regs.vh */
// register map, field positions and reset values of the remote/local block
`ifndef RLC_REGS_VH
`define RLC_REGS_VH

// ***********************************************************
// register byte offsets
// ***********************************************************
`define RLC_OFF_CMD_SERIAL 8'h00
`define RLC_OFF_CMD_GPIB 8'h04
`define RLC_OFF_CTRL 8'h08
`define RLC_OFF_STATUS 8'h0c
`define RLC_OFF_TEMP_SET 8'h10
`define RLC_OFF_TEMP_READ 8'h14

// ***********************************************************
// command word bit positions
// ***********************************************************
`define RLC_CMD_LOCAL 0
`define RLC_CMD_REMOTE 1
`define RLC_CMD_LOCK_SET 2
`define RLC_CMD_LOCK_CLR 3
`define RLC_CMD_START 4
`define RLC_CMD_READQ 5
`define RLC_CMD_MEASQ 6
`define RLC_CMD_ABORT 7
`define RLC_CMD_TRIG 8
`define RLC_CMD_OUT_ON 9
`define RLC_CMD_UNIT_WR 10
`define RLC_CMD_UNIT_LSB 11
`define RLC_CMD_UNIT_MSB 13

// ***********************************************************
// unit parameter names and internal unit codes
// ***********************************************************
`define RLC_NAME_C 3'h0
`define RLC_NAME_CEL 3'h1
`define RLC_NAME_F 3'h2
`define RLC_NAME_FAR 3'h3
`define RLC_NAME_K 3'h4
`define RLC_UNIT_C 2'h0
`define RLC_UNIT_F 2'h1
`define RLC_UNIT_K 2'h2

// ***********************************************************
// control and status fields, reset values
// ***********************************************************
`define RLC_CTRL_CAL 0
`define RLC_ST_REMOTE 0
`define RLC_ST_LOCKOUT 1
`define RLC_ST_IDLE 2
`define RLC_ST_OUTPUT 3
`define RLC_ST_KEYS_EN 4
`define RLC_ST_CAL 5
`define RLC_ST_UNIT_LSB 6
`define RLC_ST_UNIT_MSB 7
`define RLC_RST_UNIT 2'h0
`define RLC_RST_SETPOINT 32'h00006978

`endif

/* design/rlc_temp_conv.v */
// converts millidegree values between celsius and the selected unit
`timescale 1ns/10ps
`default_nettype none
`include "rlc_regs.vh"

module rlc_temp_conv (
	input wire [1:0] unit,
	input wire [31:0] user_in,
	input wire [31:0] cel_in,
	output reg [31:0] cel_out,
	output reg [31:0] user_out
);
	localparam signed [63:0] KOFS = 64'sd273150;
	localparam signed [63:0] FOFS = 64'sd32000;
	reg signed [63:0] a;
	reg signed [63:0] b;

	// widened to 64 bits so the x9 and x5 products cannot overflow
	always @* begin
		a = {{32{user_in[31]}}, user_in};
		b = {{32{cel_in[31]}}, cel_in};
		case (unit)
			`RLC_UNIT_F: begin
				a = ((a - FOFS) * 64'sd5) / 64'sd9;
				b = (b * 64'sd9) / 64'sd5 + FOFS;
			end
			`RLC_UNIT_K: begin
				a = a - KOFS;
				b = b + KOFS;
			end
			default: begin
				a = a;
				b = b;
			end
		endcase
		cel_out = a[31:0];
		user_out = b[31:0];
	end
endmodule // rlc_temp_conv
`default_nettype wire

/* tb/rlc_control_chk.sv */
// concurrent checks on the ports of the remote/local control block
`timescale 1ns/10ps
`default_nettype none
`include "rlc_regs.vh"

module rlc_control_chk (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic key_valid,
	input wire logic [5:0] key_code,
	input wire logic key_output_off,
	input wire logic remote,
	input wire logic lockout,
	input wire logic idle,
	input wire logic output_on,
	input wire logic key_pass,
	input wire logic [5:0] key_pass_code,
	input wire logic trigger_fire,
	input wire logic result_req,
	input wire logic [1:0] unit_sel
);
	logic take;
	logic cal_q;
	logic [31:0] cmd_q;
	// ********
	// helper state
	// ********
	// a command word counts only at the completing edge of a write
	assign take = ce && psel && penable && pready && pwrite &&
		(paddr == `RLC_OFF_CMD_SERIAL || paddr == `RLC_OFF_CMD_GPIB);
	// shadow of the calibration flag, the word is kept for one cycle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cal_q <= 1'b0;
		end else if (ce && psel && penable && pready && pwrite &&
			paddr == `RLC_OFF_CTRL) begin
			cal_q <= pwdata[0];
		end
	end
	always_ff @(posedge clk_sys) begin
		cmd_q <= pwdata;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_answer;
		!pready ##1 pready;
	endsequence
	sequence s_result;
		!idle ##[0:1] result_req;
	endsequence
	property p_apb_wait;
		psel && $rose(penable) |-> s_answer;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("apb wait wrong");
	property p_local;
		take && pwdata[0] |=> !remote;
	endproperty
	a_local: assert property (p_local) else $error("still remote");
	property p_remote;
		take && pwdata[1] && !pwdata[0] |=> remote;
	endproperty
	a_remote: assert property (p_remote) else $error("not remote");
	property p_lock;
		take && (pwdata[2] || pwdata[3]) |=> lockout == cmd_q[2];
	endproperty
	a_lock: assert property (p_lock) else $error("lock flag wrong");
	// keys count only on enabled edges; ce low freezes the key path
	property p_key_block;
		ce && key_valid && !key_output_off && remote && lockout |=> !key_pass;
	endproperty
	a_key_block: assert property (p_key_block)
		else $error("key leaked");
	property p_key_pass;
		ce && key_valid && !key_output_off && !(remote && lockout) |=>
			key_pass && key_pass_code == $past(key_code);
	endproperty
	a_key_pass: assert property (p_key_pass) else $error("key lost");
	property p_off_key;
		ce && key_valid && key_output_off |=> !output_on;
	endproperty
	a_off_key: assert property (p_off_key) else $error("output on");
	property p_trig;
		take && pwdata[8] |=> trigger_fire == cal_q;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger wrong");
	property p_start;
		take && pwdata[4] && !pwdata[7] |=> !idle;
	endproperty
	a_start: assert property (p_start) else $error("still idle");
	property p_query;
		take && (pwdata[5] || pwdata[6]) && !pwdata[7] |=> s_result;
	endproperty
	a_query: assert property (p_query) else $error("no result");
	property p_abort;
		take && pwdata[7] |=> idle && !output_on;
	endproperty
	a_abort: assert property (p_abort) else $error("abort failed");
	property p_unit;
		take && pwdata[10] |=> (cmd_q[13:11] > 3'h4) ?
			$stable(unit_sel) : unit_sel == cmd_q[13:12];
	endproperty
	a_unit: assert property (p_unit) else $error("unit wrong");
endmodule // rlc_control_chk
`default_nettype wire

/* tb/rlc_panel_model.sv */
// front-panel keypad and sensor model beside the control block
`timescale 1ns/10ps
`default_nettype none

module rlc_panel_model (
	input wire logic clk_sys,
	output logic key_valid,
	output logic [5:0] key_code,
	output logic key_output_off,
	output logic [31:0] reading_c
);
	// idle keypad, sensor at 25.000 degrees
	initial begin
		key_valid = 1'b0;
		key_code = 6'h00;
		key_output_off = 1'b0;
		reading_c = 32'h000061a8;
	end
	// one key event lasts one clock; code and qualifier flip after it
	// so a late sample never sees the old key still standing
	task automatic press(input logic [5:0] code, input logic off);
		@(posedge clk_sys);
		key_valid <= 1'b1;
		key_code <= code;
		key_output_off <= off;
		@(posedge clk_sys);
		key_valid <= 1'b0;
		key_code <= ~code;
		key_output_off <= ~off;
	endtask
	task automatic set_reading(input logic [31:0] v);
		@(posedge clk_sys);
		reading_c <= v;
	endtask
endmodule // rlc_panel_model
`default_nettype wire

/* tb/rlc_testbench.sv */
// self-checking bench of the remote/local control block
`timescale 1ns/10ps
`default_nettype none
`include "rlc_regs.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	n_errors++; $display("mismatch %s expected %h seen %h", nm, e, g); end end

module testbench;
	typedef struct packed {
		logic [7:0] a;
		logic [15:0] d;
		logic [7:0] s;
	} rlc_row_t;
	logic clk_sys, reset_n, ce, psel, penable, pwrite, pready, pslverr, err;
	logic key_valid, key_output_off, remote, lockout, idle, output_on;
	logic key_pass, trigger_fire, result_req;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, reading_c, setpoint_c, rd;
	logic [5:0] key_code, key_pass_code;
	logic [1:0] unit_sel;
	int n_errors = 0;
	int samples_checked = 0;
	// port, command word, status expected after it
	rlc_row_t rows [0:17] = '{
		'{8'h00, 16'h0002, 8'h15}, '{8'h04, 16'h0004, 8'h07},
		'{8'h00, 16'h0200, 8'h0f}, '{8'h04, 16'h0010, 8'h0b},
		'{8'h00, 16'h0080, 8'h07}, '{8'h04, 16'h0001, 8'h16},
		'{8'h00, 16'h0003, 8'h16}, '{8'h04, 16'h000a, 8'h15},
		'{8'h00, 16'h1400, 8'h55}, '{8'h04, 16'h0c00, 8'h15},
		'{8'h00, 16'h1c00, 8'h55}, '{8'h04, 16'h2400, 8'h95},
		'{8'h00, 16'h3c00, 8'h95}, '{8'h04, 16'h0400, 8'h15},
		'{8'h00, 16'h0020, 8'h11}, '{8'h04, 16'h0080, 8'h15},
		'{8'h00, 16'h0040, 8'h11}, '{8'h04, 16'h0090, 8'h15}};

	rlc_control rlc_control_inst (.clk_sys, .reset_n, .ce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .key_valid,
		.key_code, .key_output_off, .reading_c, .remote, .lockout, .idle,
		.output_on, .key_pass, .key_pass_code, .trigger_fire, .result_req,
		.unit_sel, .setpoint_c);
	rlc_panel_model rlc_panel_model_inst (.clk_sys, .key_valid, .key_code,
		.key_output_off, .reading_c);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// ********
	// bus tasks
	// ********
	// one transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// no wait count is assumed; only the watchdog ends a hang
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("prdata", e, rd)
	endtask
	task automatic test_done;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// the whole run is a few hundred cycles; this cuts a hang
	initial begin
		#50000;
		n_errors++;
		test_done;
	end
	// ********
	// main sequence
	// ********
	initial begin
		reset_n = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1;
		`CHK("setpoint_c", 32'h00006978, setpoint_c)
		rc(`RLC_OFF_STATUS, 32'h00000014);
		foreach (rows[i]) begin
			wr(rows[i].a, {16'h0, rows[i].d});
			rc(`RLC_OFF_STATUS,
				{24'h0, rows[i].s});
		end
		wr(`RLC_OFF_CMD_SERIAL, 32'h00000004);
		rlc_panel_model_inst.press(6'h05, 1'b0);
		#1;
		`CHK("key_pass", 1'b0, key_pass)
		wr(`RLC_OFF_CMD_GPIB, 32'h00000200);
		rlc_panel_model_inst.press(6'h07, 1'b1);
		#1;
		`CHK("output_on", 1'b0, output_on)
		wr(`RLC_OFF_CMD_SERIAL, 32'h00000008);
		rlc_panel_model_inst.press(6'h2a, 1'b0);
		#1;
		`CHK("key_pass", 1'b1, key_pass)
		`CHK("key_pass_code", 6'h2a, key_pass_code)
		wr(`RLC_OFF_CMD_GPIB, 32'h00000006);
		wr(`RLC_OFF_CMD_SERIAL, 32'h00000001);
		rlc_panel_model_inst.press(6'h11, 1'b0);
		#1;
		`CHK("key_pass", 1'b1, key_pass)
		// clock enable low must freeze the key path as well
		@(posedge clk_sys);
		ce <= 1'b0;
		rlc_panel_model_inst.press(6'h09, 1'b0);
		#1;
		`CHK("key_pass", 1'b0, key_pass)
		`CHK("key_pass_code", 6'h11, key_pass_code)
		@(posedge clk_sys);
		ce <= 1'b1;
		wr(`RLC_OFF_CMD_SERIAL, 32'h00000100);
		#1;
		`CHK("trigger_fire", 1'b0, trigger_fire)
		wr(`RLC_OFF_CTRL, 32'h00000001);
		wr(`RLC_OFF_CMD_GPIB, 32'h00000100);
		#1;
		`CHK("trigger_fire", 1'b1, trigger_fire)
		wr(`RLC_OFF_CTRL, 32'h0);
		// the unmapped place must refuse; neither it nor the read-only status may change anything
		wr(8'h18, 32'h00000002);
		`CHK("pslverr", 1'b1, err)
		wr(`RLC_OFF_STATUS, 32'h0);
		rc(`RLC_OFF_STATUS, 32'h00000016);
		// kelvin, then fahrenheit, on both set value and reading
		wr(`RLC_OFF_CMD_SERIAL, 32'h00002400);
		rc(`RLC_OFF_TEMP_READ, 32'h00048ca6);
		wr(`RLC_OFF_TEMP_SET, 32'h0004bb86);
		#1;
		`CHK("setpoint_c", 32'h00009088, setpoint_c)
		wr(`RLC_OFF_CMD_GPIB, 32'h00001400);
		rc(`RLC_OFF_TEMP_SET, 32'h00018128);
		rc(`RLC_OFF_TEMP_READ, 32'h00012cc8);
		rlc_panel_model_inst.set_reading(32'hffff63c0);
		rc(`RLC_OFF_TEMP_READ, 32'hffff63c0);
		// a query from idle pulses the result request at once
		wr(`RLC_OFF_CMD_GPIB, 32'h00000040);
		#1;
		`CHK("result_req", 1'b1, result_req)
		`CHK("idle", 1'b0, idle)
		@(posedge clk_sys);
		reset_n <= 1'b0;
		@(posedge clk_sys);
		reset_n <= 1'b1;
		rc(`RLC_OFF_STATUS, 32'h00000014);
		test_done;
	end
endmodule // testbench

bind rlc_control rlc_control_chk rlc_control_chk_inst (.clk_sys, .reset_n,
	.ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .key_valid,
	.key_code, .key_output_off, .remote, .lockout, .idle, .output_on,
	.key_pass, .key_pass_code, .trigger_fire, .result_req, .unit_sel);
`default_nettype wire
